// File: rtl/i2cr_cfg_port.sv
`timescale 1ns/100ps
`default_nettype none
module i2cr_cfg_port (
  input wire logic clk_sys,
  input wire logic arst_n,
  i2cr_req_if.port req,
  input wire logic bridged_partition_mode,
  output var logic cfg_req,
  output var logic cfg_we,
  output var logic [3:0] cfg_port,
  output var logic cfg_link_side,
  output var logic cfg_virt_side,
  output var logic [11:0] cfg_addr,
  output var logic [3:0] cfg_be,
  output var logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  logic take;
  logic done;

  // a go while an access is still open is dropped
  assign take = req.go & ~cfg_req;
  assign done = cfg_req & cfg_ack;
  assign req.busy = cfg_req;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_req <= 1'h0;
      cfg_we <= 1'h0;
      cfg_port <= 4'h0;
      cfg_link_side <= 1'h0;
      cfg_virt_side <= 1'h0;
      cfg_addr <= 12'h000;
      cfg_be <= 4'h0;
      cfg_wdata <= 32'h0000_0000;
    end else if (take) begin
      cfg_req <= 1'h1;
      cfg_we <= req.we;
      cfg_port <= req.sel[3:0]; // [RULE12]
      cfg_link_side <= (req.sel == i2cr_pkg::PORT_LINK) & bridged_partition_mode; // [RULE12]
      cfg_virt_side <= (req.sel == i2cr_pkg::PORT_VIRT); // [RULE12]
      cfg_addr <= {req.dw_addr, i2cr_pkg::ADDR_PAD}; // [RULE14]
      cfg_be <= req.be; // [RULE13] [RULE21]
      cfg_wdata <= req.wdata;
    end else if (done) begin
      cfg_req <= 1'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      req.rbuf <= 32'h0000_0000;
    end else if (done && !cfg_we) begin
      req.rbuf <= cfg_rdata; // [RULE17]
    end
  end
endmodule : i2cr_cfg_port
`default_nettype wire

// File: rtl/i2cr_pkg.sv
package i2cr_pkg;

  // slave address: upper bits fixed, low bits from the select pins
  localparam logic [6:0] SLV_ADDR_BASE = 7'h38;
  localparam int ADDR_PIN_W = 3;

  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_READ = 3'h4;

  localparam logic [4:0] PORT_LINK = 5'h01;
  localparam logic [4:0] PORT_VIRT = 5'h10;

  // byte index within one packet, saturating at the extra-byte value
  localparam logic [3:0] IDX_ADDR = 4'h0;
  localparam logic [3:0] IDX_CMD_FIRST = 4'h1;
  localparam logic [3:0] IDX_CMD_LAST = 4'h4;
  localparam logic [3:0] IDX_DATA_FIRST = 4'h5;
  localparam logic [3:0] IDX_DATA_LAST = 4'h8;
  localparam logic [3:0] IDX_EXTRA = 4'h9;

  localparam logic [3:0] BIT_FULL = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h7;

  // field positions in the 32-bit word of four command bytes
  localparam int OP_LSB = 24;
  localparam int SEL_HI_LSB = 16;
  localparam int SEL_LO_BIT = 15;
  localparam int BE_LSB = 10;
  localparam int AHI_LSB = 8;
  localparam int ALO_LSB = 0;
  localparam logic [1:0] ADDR_PAD = 2'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX = 5'h02,
    ST_RX_ACK = 5'h04,
    ST_TX = 5'h08,
    ST_TX_ACK = 5'h10
  } i2cr_state_t;

endpackage : i2cr_pkg

// File: rtl/i2cr_req_if.sv
`timescale 1ns/100ps
`default_nettype none
interface i2cr_req_if;
  logic go;
  logic we;
  logic [4:0] sel;
  logic [9:0] dw_addr;
  logic [3:0] be;
  logic [31:0] wdata;
  logic [31:0] rbuf;
  logic busy;
  modport ctl (output go, output we, output sel, output dw_addr, output be, output wdata, input rbuf, input busy);
  modport port (input go, input we, input sel, input dw_addr, input be, input wdata, output rbuf, output busy);
endinterface : i2cr_req_if
`default_nettype wire

// File: rtl/i2cr_sync.sv
`timescale 1ns/100ps
`default_nettype none
module i2cr_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] d_async,
  output var logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
        meta_reg[i] <= RST_VAL[i];
        q[i] <= RST_VAL[i];
      end else begin
        meta_reg[i] <= d_async[i];
        q[i] <= meta_reg[i];
      end
    end
  end
endmodule : i2cr_sync
`default_nettype wire

// File: rtl/i2cr_top.sv
// What this block does
// [RULE1] answer address 38h plus select pins
// [RULE2] sample three select pins for address
// [RULE3] software override replaces the slave address
// [RULE4] master writes: address, four commands, data
// [RULE5] invalid command leaves target register untouched
// [RULE6] first data byte is bits 31:24
// [RULE7] master always sends four data bytes
// [RULE8] master ends with stop or repeated start
// [RULE9] nak every write data byte past fourth
// [RULE10] opcode 011b writes, 100b reads
// [RULE11] port select from byte1[3:0], byte2[7]
// [RULE12] decode port select, 11h-1Fh reserved
// [RULE13] byte enables in byte2 bits 5:2
// [RULE14] dword address from byte2[1:0], byte3
// [RULE15] read: command packet then read packet
// [RULE16] address bit0 set means read cycle
// [RULE17] read command latches register into buffer
// [RULE18] send buffer most significant byte first
// [RULE19] past four read bytes, wrap around
// [RULE20] packets may join through repeated start
// [RULE21] accepted write issues one dword access
`timescale 1ns/100ps
`default_nettype none
module i2cr_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output var logic sda_out,
  output var logic sda_oe,
  input wire logic [2:0] addr_sel_pins,
  input wire logic dev_addr_ovr_en,
  input wire logic [6:0] dev_addr_ovr,
  input wire logic bridged_partition_mode,
  output var logic link_active,
  output var logic cfg_req,
  output var logic cfg_we,
  output var logic [3:0] cfg_port,
  output var logic cfg_link_side,
  output var logic cfg_virt_side,
  output var logic [11:0] cfg_addr,
  output var logic [3:0] cfg_be,
  output var logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  i2cr_req_if req ();

  logic [4:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic [2:0] addr_s;
  logic scl_d_reg;
  logic sda_d_reg;

  i2cr_pkg::i2cr_state_t state_reg;
  i2cr_pkg::i2cr_state_t state_next;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [3:0] byte_idx_reg;
  logic [3:0] byte_idx_next;
  logic [7:0] shreg_reg;
  logic [7:0] shreg_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [1:0] tx_sel_reg;
  logic [1:0] tx_sel_next;
  logic [31:0] cmd_reg;
  logic [31:0] cmd_next;
  logic [31:0] wdata_reg;
  logic [31:0] wdata_next;
  logic rw_reg;
  logic rw_next;
  logic mack_reg;
  logic mack_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic go_reg;
  logic go_next;
  logic we_reg;
  logic we_next;
  logic active_reg;

  // pins cross into clk_sys; scl is only sampled, never a clock
  // bus pins idle high; a low reset value would fake an edge after reset
  i2cr_sync #(
    .W(5),
    .RST_VAL(5'h18)
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d_async({scl_in, sda_in, addr_sel_pins}),
    .q(sync_q)
  );

  assign scl_s = sync_q[4];
  assign sda_s = sync_q[3];
  assign addr_s = sync_q[2:0];

  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s; // [RULE20]
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  wire [6:0] pin_addr = i2cr_pkg::SLV_ADDR_BASE | {4'h0, addr_s}; // [RULE1] [RULE2]
  wire [6:0] own_addr = dev_addr_ovr_en ? dev_addr_ovr : pin_addr; // [RULE3]
  wire addr_match = (shreg_reg[7:1] == own_addr);

  // command fields
  wire [2:0] cmd_op = cmd_reg[i2cr_pkg::OP_LSB +: 3]; // [RULE10]
  wire [4:0] cmd_sel = {cmd_reg[i2cr_pkg::SEL_HI_LSB +: 4], cmd_reg[i2cr_pkg::SEL_LO_BIT]}; // [RULE11]
  wire [3:0] cmd_be = cmd_reg[i2cr_pkg::BE_LSB +: 4]; // [RULE13]
  wire [9:0] cmd_dw = {cmd_reg[i2cr_pkg::AHI_LSB +: 2], cmd_reg[i2cr_pkg::ALO_LSB +: 8]}; // [RULE14]
  wire port_ok = (cmd_sel <= i2cr_pkg::PORT_VIRT); // [RULE12]
  wire is_wr = (cmd_op == i2cr_pkg::OP_WRITE) & port_ok; // [RULE5]
  wire is_rd = (cmd_op == i2cr_pkg::OP_READ) & port_ok; // [RULE5]

  wire idx_is_addr = (byte_idx_reg == i2cr_pkg::IDX_ADDR);
  wire idx_is_cmd = (byte_idx_reg >= i2cr_pkg::IDX_CMD_FIRST) & (byte_idx_reg <= i2cr_pkg::IDX_CMD_LAST);
  wire idx_is_data = (byte_idx_reg >= i2cr_pkg::IDX_DATA_FIRST) & (byte_idx_reg <= i2cr_pkg::IDX_DATA_LAST);
  // data bytes only for a valid write; fifth and later fall outside idx_is_data
  wire byte_ok = (idx_is_addr & addr_match) | idx_is_cmd | (idx_is_data & is_wr); // [RULE9]
  wire byte_done = scl_fall & (bit_cnt_reg == i2cr_pkg::BIT_FULL);
  wire issue_rd = (byte_idx_reg == i2cr_pkg::IDX_CMD_LAST) & is_rd; // [RULE17]
  wire issue_wr = (byte_idx_reg == i2cr_pkg::IDX_DATA_LAST) & is_wr; // [RULE21]
  wire [3:0] idx_inc = (byte_idx_reg == i2cr_pkg::IDX_EXTRA) ? byte_idx_reg : byte_idx_reg + 4'h1;

  // buffer byte by pointer: 0 picks bits 31:24, wraps after 7:0
  wire [7:0] tx_byte = req.rbuf[{~tx_sel_reg, 3'h0} +: 8]; // [RULE18] [RULE19]

  assign req.go = go_reg;
  // byte index has moved on once go is seen, so direction rides with go
  assign req.we = we_reg; // [RULE21]
  assign req.sel = cmd_sel;
  assign req.dw_addr = cmd_dw;
  assign req.be = cmd_be;
  assign req.wdata = wdata_reg;

  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    byte_idx_next = byte_idx_reg;
    shreg_next = shreg_reg;
    tx_next = tx_reg;
    tx_sel_next = tx_sel_reg;
    cmd_next = cmd_reg;
    wdata_next = wdata_reg;
    rw_next = rw_reg;
    mack_next = mack_reg;
    sda_oe_next = sda_oe_reg;
    go_next = 1'h0;
    we_next = issue_wr;
    if (stop_det) begin
      state_next = i2cr_pkg::ST_IDLE;
      sda_oe_next = 1'h0;
    end else if (start_det) begin
      state_next = i2cr_pkg::ST_RX;
      bit_cnt_next = 4'h0;
      byte_idx_next = i2cr_pkg::IDX_ADDR;
      tx_sel_next = 2'h0;
      sda_oe_next = 1'h0;
    end else begin
      unique case (state_reg)
        i2cr_pkg::ST_IDLE: begin
          sda_oe_next = 1'h0;
        end
        i2cr_pkg::ST_RX: begin
          if (scl_rise) begin
            shreg_next = {shreg_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            if (byte_ok) begin
              sda_oe_next = 1'h1;
              state_next = i2cr_pkg::ST_RX_ACK;
              if (idx_is_addr) begin
                rw_next = shreg_reg[0]; // [RULE16]
              end
              if (idx_is_cmd) begin
                cmd_next = {cmd_reg[23:0], shreg_reg};
              end
              if (idx_is_data) begin
                wdata_next = {wdata_reg[23:0], shreg_reg}; // [RULE6]
              end
            end else begin
              // nak: stay off the bus until the next start or stop
              state_next = i2cr_pkg::ST_IDLE; // [RULE9]
            end
          end
        end
        i2cr_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_next = 1'h0;
            bit_cnt_next = 4'h0;
            byte_idx_next = idx_inc;
            go_next = issue_rd | issue_wr; // [RULE17] [RULE21]
            if (idx_is_addr && rw_reg) begin
              state_next = i2cr_pkg::ST_TX; // [RULE16]
              tx_next = tx_byte;
              tx_sel_next = tx_sel_reg + 2'h1;
              sda_oe_next = ~tx_byte[7];
            end else begin
              state_next = i2cr_pkg::ST_RX;
            end
          end
        end
        i2cr_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == i2cr_pkg::BIT_LAST) begin
              sda_oe_next = 1'h0;
              state_next = i2cr_pkg::ST_TX_ACK;
            end else begin
              sda_oe_next = ~tx_reg[6];
              tx_next = {tx_reg[6:0], 1'h0};
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        i2cr_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            mack_next = ~sda_s;
          end else if (scl_fall) begin
            if (mack_reg) begin
              state_next = i2cr_pkg::ST_TX; // [RULE19]
              bit_cnt_next = 4'h0;
              tx_next = tx_byte;
              tx_sel_next = tx_sel_reg + 2'h1;
              sda_oe_next = ~tx_byte[7];
            end else begin
              state_next = i2cr_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          state_next = i2cr_pkg::ST_IDLE;
          sda_oe_next = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
      state_reg <= i2cr_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= i2cr_pkg::IDX_ADDR;
      shreg_reg <= 8'h00;
      tx_reg <= 8'h00;
      tx_sel_reg <= 2'h0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      byte_idx_reg <= byte_idx_next;
      shreg_reg <= shreg_next;
      tx_reg <= tx_next;
      tx_sel_reg <= tx_sel_next;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= 32'h0000_0000;
      wdata_reg <= 32'h0000_0000;
      rw_reg <= 1'h0;
      mack_reg <= 1'h0;
      sda_oe_reg <= 1'h0;
      go_reg <= 1'h0;
      we_reg <= 1'h0;
      active_reg <= 1'h0;
    end else begin
      cmd_reg <= cmd_next;
      wdata_reg <= wdata_next;
      rw_reg <= rw_next;
      mack_reg <= mack_next;
      sda_oe_reg <= sda_oe_next;
      go_reg <= go_next;
      we_reg <= we_next;
      active_reg <= (state_next != i2cr_pkg::ST_IDLE);
    end
  end

  // open drain: the driven level is always low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_out <= 1'h0;
    end else begin
      sda_out <= 1'h0;
    end
  end

  assign sda_oe = sda_oe_reg;
  assign link_active = active_reg;

  i2cr_cfg_port u_cfg (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .req(req),
    .bridged_partition_mode(bridged_partition_mode),
    .cfg_req(cfg_req),
    .cfg_we(cfg_we),
    .cfg_port(cfg_port),
    .cfg_link_side(cfg_link_side),
    .cfg_virt_side(cfg_virt_side),
    .cfg_addr(cfg_addr),
    .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata)
  );
endmodule : i2cr_top
`default_nettype wire

// File: tb/i2cr_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2cr_master_model (
  output var logic scl,
  output var logic sda_pull,
  input wire logic sda
);
  // clock stands high between frames, no free run
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    #10 sda_pull = ~b;
    #30 scl = 1'b1;
    #20 r = sda;
    #20;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic nak, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(nak, r);
    ack = ~r;
  endtask : xfer
  // also serves as repeated start
  task automatic start();
    scl = 1'b0;
    #10 sda_pull = 1'b0;
    #30 scl = 1'b1;
    #40 sda_pull = 1'b1;
    #40;
  endtask : start
  task automatic stop();
    scl = 1'b0;
    #10 sda_pull = 1'b1;
    #30 scl = 1'b1;
    #40 sda_pull = 1'b0;
    #40;
  endtask : stop
endmodule : i2cr_master_model
`default_nettype wire

// File: tb/i2cr_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module i2cr_top_asserts (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic bridged_partition_mode,
  input wire logic link_active,
  input wire logic cfg_req,
  input wire logic [3:0] cfg_port,
  input wire logic cfg_link_side,
  input wire logic cfg_virt_side,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_ack
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_fields_stable: assert property (
    cfg_req && $past(cfg_req) |-> $stable({cfg_addr, cfg_be, cfg_wdata, cfg_port}))
    else $error("access fields moved while open");
  a_drop_after_ack: assert property (cfg_req && cfg_ack |=> !cfg_req)
    else $error("access still open after ack");
  a_issue_in_pkt: assert property ($rose(cfg_req) |-> link_active)
    else $error("access issued outside a packet");
  a_addr_aligned: assert property (cfg_req |-> cfg_addr[1:0] == 2'h0)
    else $error("access address not dword aligned");
  a_virt_side: assert property (
    cfg_req && cfg_virt_side |-> cfg_port == 4'h0 && !cfg_link_side)
    else $error("virtual side with wrong port");
  a_link_side: assert property (
    cfg_req && cfg_link_side |-> bridged_partition_mode && cfg_port == 4'h1)
    else $error("link side flagged wrongly");
  a_idle_quiet: assert property (!link_active && !$past(link_active) |-> !sda_oe)
    else $error("data line pulled while idle");
  // data may only move in the low phase of the bus clock
  a_sda_held_high: assert property (scl_in [*6] |-> $stable(sda_oe))
    else $error("data line moved while clock high");
endmodule : i2cr_top_asserts
bind i2cr_top i2cr_top_asserts i_i2cr_top_asserts (.clk_sys, .arst_n, .scl_in, .sda_oe,
  .bridged_partition_mode, .link_active, .cfg_req, .cfg_port, .cfg_link_side, .cfg_virt_side,
  .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack);
`default_nettype wire

// File: tb/i2cr_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
module i2cr_top_bench;
  typedef struct packed {logic [4:0] sel; logic [3:0] be; logic [9:0] adw; logic [31:0] data; logic mode;} i2cr_row_t;
  logic clk_sys, arst_n, scl, m_pull, sda_bus, sda_out, sda_oe, dev_addr_ovr_en, bridged_partition_mode;
  logic link_active, cfg_req, cfg_we, cfg_link_side, cfg_virt_side, cfg_ack;
  logic [2:0] addr_sel_pins;
  logic [6:0] dev_addr_ovr;
  logic [3:0] cfg_port, cfg_be;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [54:0] snap;
  logic [7:0] q;
  logic a;
  int n_acc, n0, bad_count, n_checks;
  i2cr_row_t rows [5] = '{'{5'h00, 4'hF, 10'h03E, 32'h12345678, 1'b0},
    '{5'h01, 4'h5, 10'h2A1, 32'hCAFE0001, 1'b1}, '{5'h01, 4'h3, 10'h000, 32'hFFFFFFFF, 1'b0},
    '{5'h10, 4'hA, 10'h155, 32'h80000001, 1'b1}, '{5'h0F, 4'h8, 10'h3FF, 32'h00FF00FF, 1'b0}};
  assign sda_bus = ~(m_pull | (sda_oe & ~sda_out));
  i2cr_master_model i_i2cr_master_model (.scl(scl), .sda_pull(m_pull), .sda(sda_bus));
  i2cr_top i_i2cr_top (.clk_sys(clk_sys), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_bus),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_pins(addr_sel_pins), .dev_addr_ovr_en(dev_addr_ovr_en),
    .dev_addr_ovr(dev_addr_ovr), .bridged_partition_mode(bridged_partition_mode), .link_active(link_active),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_port(cfg_port), .cfg_link_side(cfg_link_side),
    .cfg_virt_side(cfg_virt_side), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));
  always #5 clk_sys = ~clk_sys;
  // fabric stand-in: answers each access one cycle after it opens
  always @(posedge clk_sys) begin
    cfg_ack <= #1 cfg_req & ~cfg_ack;
    if (cfg_req & ~cfg_ack) begin
      n_acc <= n_acc + 1;
      snap <= {cfg_we, cfg_port, cfg_link_side, cfg_virt_side, cfg_addr, cfg_be, cfg_wdata};
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic put(input logic [7:0] d, input logic exp_ack);
    logic [7:0] r;
    logic ak;
    i_i2cr_master_model.xfer(d, 1'b1, r, ak);
    chk("ack", 64'(exp_ack), 64'(ak));
  endtask : put
  // reserved command bits set on purpose, they must be ignored
  task automatic cmd(input logic [2:0] op, input logic [4:0] sel, input logic [3:0] be, input logic [9:0] adw);
    i_i2cr_master_model.start();
    put(8'h70, 1'b1);
    put({5'h1F, op}, 1'b1);
    put({4'hA, sel[4:1]}, 1'b1);
    put({sel[0], 1'b1, be, adw[9:8]}, 1'b1);
    put(adw[7:0], 1'b1);
  endtask : cmd
  task automatic wr(input i2cr_row_t r, input logic exp_ack);
    cmd(i2cr_pkg::OP_WRITE, r.sel, r.be, r.adw);
    for (int k = 3; k >= 0; k--) begin
      put(r.data[8*k +: 8], exp_ack);
    end
  endtask : wr
  task automatic probe(input logic [6:0] sa, input logic exp_ack);
    i_i2cr_master_model.start();
    put({sa, 1'b0}, exp_ack);
    i_i2cr_master_model.stop();
  endtask : probe
  task automatic rd(input int n, input logic [31:0] v);
    put(8'h71, 1'b1);
    for (int k = 0; k < n; k++) begin
      i_i2cr_master_model.xfer(8'hFF, k == n - 1, q, a);
      chk("rdbyte", 64'(v[31 - 8 * (k % 4) -: 8]), 64'(q));
    end
    i_i2cr_master_model.stop();
  endtask : rd
  initial begin
    #400000;
    bad_count++;
    $display("ERROR watchdog expired");
    finish_test();
  end
  initial begin
    {clk_sys, arst_n, dev_addr_ovr_en, bridged_partition_mode, cfg_ack, n_acc} = '0;
    {addr_sel_pins, dev_addr_ovr, cfg_rdata} = '0;
    repeat (8) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    chk("reset", 64'h0, 64'({sda_oe, cfg_req, link_active}));
    repeat (4) @(posedge clk_sys);
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk_sys) #1 bridged_partition_mode = rows[i].mode;
      n0 = n_acc;
      wr(rows[i], 1'b1);
      i_i2cr_master_model.stop();
      chk("count", 64'(n0 + 1), 64'(n_acc));
      chk("fields", {1'b1, rows[i].sel == 5'h10 ? 4'h0 : rows[i].sel[3:0], rows[i].sel == 5'h01 && rows[i].mode,
        rows[i].sel == 5'h10, rows[i].adw, 2'h0, rows[i].be, rows[i].data}, snap);
    end
    $display("test write table done");
    n0 = n_acc;
    wr(rows[0], 1'b1);
    put(8'hEE, 1'b0);
    i_i2cr_master_model.stop();
    wr('{5'h00, 4'hF, 10'h001, 32'h55AA55AA, 1'b0}, 1'b1);
    i_i2cr_master_model.start();
    put(8'h70, 1'b1);
    i_i2cr_master_model.stop();
    chk("count", 64'(n0 + 2), 64'(n_acc));
    wr('{5'h11, 4'hF, 10'h001, 32'h0, 1'b0}, 1'b0);
    i_i2cr_master_model.stop();
    cmd(3'h5, 5'h00, 4'hF, 10'h001);
    put(8'h11, 1'b0);
    i_i2cr_master_model.stop();
    chk("count", 64'(n0 + 2), 64'(n_acc));
    $display("test refused writes done");
    @(posedge clk_sys) #1 cfg_rdata = 32'hA1B2C3D4;
    cmd(i2cr_pkg::OP_READ, 5'h03, 4'hF, 10'h001);
    i_i2cr_master_model.start();
    rd(5, 32'hA1B2C3D4);
    chk("rdacc", {1'b0, 4'h3, 2'h0, 12'h004}, snap[54:36]);
    @(posedge clk_sys) #1 cfg_rdata = 32'h0F0F0F0F;
    n0 = n_acc;
    cmd(i2cr_pkg::OP_READ, 5'h11, 4'hF, 10'h001);
    i_i2cr_master_model.stop();
    chk("count", 64'(n0), 64'(n_acc));
    i_i2cr_master_model.start();
    rd(1, 32'hA1B2C3D4);
    $display("test read done");
    n0 = n_acc;
    cmd(i2cr_pkg::OP_WRITE, 5'h02, 4'hF, 10'h010);
    @(posedge clk_sys) #1 arst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("midreset", 64'h0, 64'({sda_oe, sda_out, cfg_req, cfg_we, cfg_addr, link_active}));
    arst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1 i_i2cr_master_model.stop();
    chk("count", 64'(n0), 64'(n_acc));
    $display("test mid reset done");
    @(posedge clk_sys) #1 addr_sel_pins = 3'h5;
    repeat (4) @(posedge clk_sys);
    probe(7'h38, 1'b0);
    probe(7'h3D, 1'b1);
    @(posedge clk_sys) #1 dev_addr_ovr = 7'h22;
    dev_addr_ovr_en = 1'b1;
    probe(7'h22, 1'b1);
    probe(7'h3D, 1'b0);
    $display("test slave address done");
    finish_test();
  end
endmodule : i2cr_top_bench
`default_nettype wire
